// file: rtl/eepc_ctrl.sv
// Program/erase controller with AHB-Lite register slave and array window.
// Assumes one AHB-Lite master, whole-word single transfers, one clock.
//
// Register access over AHB-Lite was decided locally.
`timescale 1ns/1ps
`include "eepc_cfg.svh"

// Operation
// - Array is four 128-byte blocks, each with its own protection bit.
// - No high voltage reaches a location inside a protected block.
// - Protection bit n guards the n-th 128-byte range, lowest first.
// - Set bit protects; new settings apply after reset or config read.
// - Redundant mode ignores protection bits 3 and 2.
// - Redundant mode mirrors lower 256 bytes onto upper 256 bytes, except for block erase.
// - Redundant mode does not recognise upper-half addresses.
// - Reset and each config read copy config byte into shadow.
// - Config byte programs and erases like any byte, effective later.
// - Pump clock select: 1 bus clock, 0 RC oscillator; reset clears.
// - Power-down disables array; reset clears; software waits recovery. Here the bit only drives array_power_down_o; reads and commits go on.
// - Erase-select encodes operation; protected target blocks all; reset clears.
// - Latch control captures writes; cannot clear while high voltage set.
// - High voltage enable acts only with latch and captured valid write.
// - Clearing latch and enable together clears only the enable.
// - Shadow is read-only: bit7 redundant, bits3..0 protection.
// - Wait mode leaves array and ongoing operation unaffected.
// - Stop removes high voltage, keeps enable bit, restores on exit.
// - Latched data reads back; later valid write replaces latch.
// - Enable cannot set without latch after non-array write.
// - Erase-select bits locked while high voltage enable is set.
// - Block and bulk erase leave the config byte unchanged.
module eepc_ctrl #(
   parameter int ADDR_W = 9
) (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   input wire logic stop_mode_i,
   output logic hv_request_o,
   output logic pump_clock_select_o,
   output logic array_power_down_o
);

   // Whole block state, one struct
   typedef struct packed {
      eepc_pkg::eepc_bus_type bus;
      logic [15:0] addr;
      logic wr;
      logic [7:0] ctrl;
      logic [7:0] shadow;
      logic [ADDR_W-1:0] lat_addr;
      logic lat_cfg;
      logic [7:0] lat_data;
      logic lat_valid;
      logic foreign_wr;
      logic reload;
      logic boot;
      logic stop_sync1;
      logic stop_sync2;
      logic hv_on;
      logic [31:0] rdata;
   } eepc_state_type;

   eepc_state_type st_r;
   eepc_state_type st_nxt;

   logic [7:0] arr_rd;
   logic [7:0] cfg_byte;
   logic commit;
   logic [ADDR_W-1:0] rd_addr;

   // Address inside the array window
   function automatic logic is_array(input logic [15:0] a);
      is_array = (a >= `EEPC_ARRAY_BASE) && (a <= `EEPC_ARRAY_LAST);
   endfunction

   // Target protection from the active shadow
   function automatic logic target_prot(input logic [ADDR_W-1:0] a,
                                        input logic [7:0] sh,
                                        input logic [1:0] op);
      logic red;
      red = sh[`EEPC_CFG_RED];
      if (op == 2'h3) begin
         target_prot = red ? |sh[1:0] : |sh[3:0];
      end else begin
         target_prot = sh[a[ADDR_W-1:ADDR_W-2]] & ~(red & a[ADDR_W-1]);
      end
   endfunction

   // Bus decode, register effects and high-voltage sequencing
   always_comb begin
      logic [15:0] a;
      logic [7:0] wd;
      logic [ADDR_W-1:0] off;
      logic valid;
      a = 16'h0000;
      wd = 8'h00;
      off = '0;
      valid = 1'b0;
      st_nxt = st_r;
      st_nxt.reload = 1'b0;
      st_nxt.stop_sync1 = stop_mode_i;
      st_nxt.stop_sync2 = st_r.stop_sync1;
      st_nxt.boot = 1'b0;
      if (st_r.boot) begin
         st_nxt.shadow = cfg_byte & `EEPC_CFG_BP_MASK;
      end
      if (st_r.reload) begin
         st_nxt.shadow = cfg_byte & `EEPC_CFG_BP_MASK;
      end
      case (st_r.bus)
         eepc_pkg::EEPC_BUS_IDLE: begin
            if (hsel_i && hready_i && htrans_i[1]) begin
               st_nxt.addr = haddr_i[15:0];
               st_nxt.wr = hwrite_i;
               st_nxt.bus = eepc_pkg::EEPC_BUS_DATA;
            end
         end
         eepc_pkg::EEPC_BUS_DATA: begin
            // One wait state lets the array read port settle
            st_nxt.bus = eepc_pkg::EEPC_BUS_WAIT;
         end
         eepc_pkg::EEPC_BUS_WAIT: begin
            a = st_r.addr;
            wd = hwdata_i[7:0];
            off = a[ADDR_W-1:0];
            valid = is_array(a) && !(st_r.shadow[`EEPC_CFG_RED] && a[ADDR_W-1]);
            st_nxt.bus = eepc_pkg::EEPC_BUS_IDLE;
            st_nxt.rdata = 32'h0000_0000;
            if (st_r.wr) begin
               if ((valid || a == `EEPC_NVCFG_ADDR) && st_r.ctrl[`EEPC_CTL_LAT] &&
                   !st_r.ctrl[`EEPC_CTL_PGM]) begin
                  st_nxt.lat_addr = off;
                  st_nxt.lat_cfg = (a == `EEPC_NVCFG_ADDR);
                  st_nxt.lat_data = wd;
                  st_nxt.lat_valid = 1'b1;
                  st_nxt.foreign_wr = 1'b0;
               end else if (a == `EEPC_CTRL_ADDR) begin
                  st_nxt.ctrl[`EEPC_CTL_BCLK] = wd[`EEPC_CTL_BCLK];
                  st_nxt.ctrl[`EEPC_CTL_OFF] = wd[`EEPC_CTL_OFF];
                  if (!st_r.ctrl[`EEPC_CTL_PGM]) begin
                     st_nxt.ctrl[`EEPC_CTL_RAS1] = wd[`EEPC_CTL_RAS1];
                     st_nxt.ctrl[`EEPC_CTL_RAS0] = wd[`EEPC_CTL_RAS0];
                  end
                  if (st_r.ctrl[`EEPC_CTL_PGM]) begin
                     st_nxt.ctrl[`EEPC_CTL_LAT] = 1'b1;
                  end else begin
                     st_nxt.ctrl[`EEPC_CTL_LAT] = wd[`EEPC_CTL_LAT];
                  end
                  if (wd[`EEPC_CTL_PGM]) begin
                     // Refused unless latch is on and a valid write was captured
                     st_nxt.ctrl[`EEPC_CTL_PGM] = st_r.ctrl[`EEPC_CTL_LAT] &&
                                                  st_r.lat_valid;
                  end else begin
                     st_nxt.ctrl[`EEPC_CTL_PGM] = 1'b0;
                  end
                  if (!wd[`EEPC_CTL_LAT] && !st_r.ctrl[`EEPC_CTL_PGM]) begin
                     st_nxt.lat_valid = 1'b0;
                  end
               end else if (!valid) begin
                  st_nxt.foreign_wr = 1'b1;
                  if (!st_r.ctrl[`EEPC_CTL_LAT]) begin
                     st_nxt.lat_valid = 1'b0;
                  end
               end
            end else begin
               if (a == `EEPC_CTRL_ADDR) begin
                  st_nxt.rdata = {24'h000000, st_r.ctrl};
               end else if (a == `EEPC_SHADOW_ADDR) begin
                  st_nxt.rdata = {24'h000000, st_r.shadow};
               end else if (a == `EEPC_NVCFG_ADDR) begin
                  st_nxt.rdata = {24'h000000, cfg_byte};
                  st_nxt.reload = 1'b1;
               end else if (a == `EEPC_STATUS_ADDR) begin
                  st_nxt.rdata = {29'h0000000, st_r.stop_sync2, st_r.hv_on,
                                  st_r.lat_valid};
               end else if (valid) begin
                  if (st_r.ctrl[`EEPC_CTL_LAT] && st_r.lat_valid) begin
                     st_nxt.rdata = {24'h000000, st_r.lat_data};
                  end else begin
                     st_nxt.rdata = {24'h000000, arr_rd};
                  end
               end
            end
         end
         default: begin
            st_nxt.bus = eepc_pkg::EEPC_BUS_IDLE;
         end
      endcase
      // Pump runs while enabled, target valid and unprotected, not stopped
      st_nxt.hv_on = st_r.ctrl[`EEPC_CTL_PGM] && st_r.ctrl[`EEPC_CTL_LAT] &&
                     st_r.lat_valid && !st_r.stop_sync2 &&
                     (st_r.lat_cfg ||
                      !target_prot(st_r.lat_addr, st_r.shadow,
                                   st_r.ctrl[`EEPC_CTL_RAS1:`EEPC_CTL_RAS0]));
   end

   // State register; reset leaves the array and config byte alone
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st_r <= '0;
         st_r.bus <= eepc_pkg::EEPC_BUS_IDLE;
         st_r.ctrl <= `EEPC_CTRL_RST;
         st_r.shadow <= `EEPC_SHADOW_RST;
         st_r.boot <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Array is altered on each rising edge of the pump request, again when it rises after stop
   assign commit = st_r.hv_on && !st_nxt.hv_on ? 1'b0 : (!st_r.hv_on && st_nxt.hv_on);
   assign rd_addr = st_r.shadow[`EEPC_CFG_RED] ? {1'b0, st_r.addr[ADDR_W-2:0]}
                                               : st_r.addr[ADDR_W-1:0];

   // Wait mode has no input here: the operation simply continues
   eepc_array #(
      .ADDR_W(ADDR_W)
   ) u_array (
      .clock_i(clock_i),
      .sys_rst_i(sys_rst_i),
      .commit_i(commit),
      .op_i(eepc_pkg::eepc_op_type'(st_r.ctrl[`EEPC_CTL_RAS1:`EEPC_CTL_RAS0])),
      .addr_i(st_r.lat_addr),
      .cfg_sel_i(st_r.lat_cfg),
      .redundant_i(st_r.shadow[`EEPC_CFG_RED]),
      .protect_i(st_r.shadow[3:0]),
      .data_i(st_r.lat_data),
      .rd_addr_i(rd_addr),
      .rd_data_o(arr_rd),
      .cfg_byte_o(cfg_byte)
   );

   // Bus answer and pins
   assign hrdata_o = st_r.rdata;
   assign hreadyout_o = (st_r.bus == eepc_pkg::EEPC_BUS_IDLE);
   assign hresp_o = 1'b0;
   assign hv_request_o = st_r.hv_on;
   assign pump_clock_select_o = st_r.ctrl[`EEPC_CTL_BCLK];
   assign array_power_down_o = st_r.ctrl[`EEPC_CTL_OFF];

endmodule

// file: shared/eepc_cfg.svh
// Constants for the array program/erase controller: offsets, fields, resets.
// Assumes inclusion from the design files by bare name; the package does not include it.
`ifndef EEPC_CFG_SVH
`define EEPC_CFG_SVH

// Register byte addresses on the bus window (16-bit window)
`define EEPC_ARRAY_BASE 16'h0800
`define EEPC_ARRAY_LAST 16'h09ff
`define EEPC_CTRL_ADDR 16'hfe1d
`define EEPC_NVCFG_ADDR 16'hfe1c
`define EEPC_SHADOW_ADDR 16'hfe1f
`define EEPC_STATUS_ADDR 16'hfe18
`define EEPC_STOP_ADDR 16'hfe14

// Control register fields
`define EEPC_CTL_PGM 0
`define EEPC_CTL_LAT 2
`define EEPC_CTL_RAS0 4
`define EEPC_CTL_RAS1 5
`define EEPC_CTL_OFF 6
`define EEPC_CTL_BCLK 7

// Shadow register fields
`define EEPC_CFG_RED 7
`define EEPC_CFG_BP_MASK 8'h8f

// Reset values
`define EEPC_CTRL_RST 8'h00
`define EEPC_SHADOW_RST 8'h00
`define EEPC_ERASED_BYTE 8'hff

// Geometry
`define EEPC_ARRAY_BYTES 512
`define EEPC_BLOCK_BYTES 128

`endif

// file: shared/eepc_pkg.sv
// Types for the array program/erase controller.
// Encodings are given here as literals; eepc_cfg.svh is not included.
package eepc_pkg;

   // Operation encoding of the erase-select pair
   typedef enum logic [1:0] {
      EEPC_OP_PROG = 2'h0,
      EEPC_OP_BYTE_ERASE = 2'h1,
      EEPC_OP_BLOCK_ERASE = 2'h2,
      EEPC_OP_BULK_ERASE = 2'h3
   } eepc_op_type;

   // Bus slave phases, one-hot
   typedef enum logic [2:0] {
      EEPC_BUS_IDLE = 3'h1,
      EEPC_BUS_DATA = 3'h2,
      EEPC_BUS_WAIT = 3'h4
   } eepc_bus_type;

endpackage

// file: rtl/eepc_array.sv
// Storage array: 512 data bytes plus the nonvolatile configuration byte.
// Assumes the controller issues at most one commit per cycle.
`timescale 1ns/1ps
`include "eepc_cfg.svh"

module eepc_array #(
   parameter int ADDR_W = 9
) (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic commit_i,
   input wire eepc_pkg::eepc_op_type op_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic cfg_sel_i,
   input wire logic redundant_i,
   input wire logic [3:0] protect_i,
   input wire logic [7:0] data_i,
   input wire logic [ADDR_W-1:0] rd_addr_i,
   output logic [7:0] rd_data_o,
   output logic [7:0] cfg_byte_o
);

   localparam int DEPTH = 1 << ADDR_W;

   // Nonvolatile contents: reset leaves them untouched, so no reset term
   logic [7:0] mem [DEPTH];
   logic [7:0] cfg_mem;
   integer i;

   // Protection of a block, upper bits meaningless when mirrored
   function automatic logic blk_prot(input logic [1:0] blk, input logic red,
                                     input logic [3:0] bp);
      blk_prot = bp[blk] & ~(red & blk[1]);
   endfunction

   // Commit applies program (clear bits) or erase (to ones)
   always_ff @(posedge clock_i) begin
      if (commit_i && cfg_sel_i) begin
         if (op_i == eepc_pkg::EEPC_OP_PROG) begin
            cfg_mem <= cfg_mem & data_i;
         end else if (op_i == eepc_pkg::EEPC_OP_BYTE_ERASE) begin
            cfg_mem <= `EEPC_ERASED_BYTE;
         end
      end else if (commit_i) begin
         for (i = 0; i < DEPTH; i = i + 1) begin
            if (!blk_prot(i[ADDR_W-1:ADDR_W-2], redundant_i, protect_i)) begin
               if (op_i == eepc_pkg::EEPC_OP_BULK_ERASE) begin
                  mem[i] <= `EEPC_ERASED_BYTE;
               end else if (op_i == eepc_pkg::EEPC_OP_BLOCK_ERASE &&
                            i[ADDR_W-1:ADDR_W-2] == addr_i[ADDR_W-1:ADDR_W-2]) begin
                  mem[i] <= `EEPC_ERASED_BYTE;
               end else if (i[ADDR_W-1:0] == addr_i ||
                            (redundant_i &&
                             i[ADDR_W-2:0] == addr_i[ADDR_W-2:0])) begin
                  if (op_i == eepc_pkg::EEPC_OP_PROG) begin
                     mem[i] <= mem[i] & data_i;
                  end else if (op_i == eepc_pkg::EEPC_OP_BYTE_ERASE) begin
                     mem[i] <= `EEPC_ERASED_BYTE;
                  end
               end
            end
         end
      end
   end

   // Registered read ports
   always_ff @(posedge clock_i) begin
      rd_data_o <= mem[rd_addr_i];
      cfg_byte_o <= cfg_mem;
   end

endmodule

// file: verification/eepc_ctrl_sva.sv
// Checker for bus timing and output behaviour of the controller.
// Assumes binding to eepc_ctrl; it sees only that module's ports.
`timescale 1ns/1ps
module eepc_ctrl_chk (
   input wire logic clock_i,
   input wire logic sys_rst_i,
   input wire logic hsel_i,
   input wire logic [1:0] htrans_i,
   input wire logic hready_i,
   input wire logic [31:0] hrdata_o,
   input wire logic hreadyout_o,
   input wire logic hresp_o,
   input wire logic stop_mode_i,
   input wire logic hv_request_o,
   input wire logic pump_clock_select_o,
   input wire logic array_power_down_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (sys_rst_i);
   logic taken;
   // Transfer accepted at this edge
   assign taken = hsel_i && hready_i && htrans_i[1] && hreadyout_o;
   property p_rst_clear;
      $fell(sys_rst_i) |-> !pump_clock_select_o && !array_power_down_o && !hv_request_o;
   endproperty
   a_rst_clear: assert property (p_rst_clear)
      else $error("control outputs not clear after reset");
   property p_ready_seq;
      taken |=> !hreadyout_o ##1 !hreadyout_o ##1 hreadyout_o;
   endproperty
   a_ready_seq: assert property (p_ready_seq)
      else $error("data phase length wrong");
   property p_idle_ready;
      hreadyout_o && !taken |=> hreadyout_o;
   endproperty
   a_idle_ready: assert property (p_idle_ready)
      else $error("ready dropped without a transfer");
   property p_upper_zero;
      $rose(hreadyout_o) |-> hrdata_o[31:8] == 24'h000000;
   endproperty
   a_upper_zero: assert property (p_upper_zero)
      else $error("upper read lanes not zero");
   property p_resp_okay;
      hresp_o == 1'b0;
   endproperty
   a_resp_okay: assert property (p_resp_okay)
      else $error("response not okay");
   // Register bits move only as a write completes
   property p_pump_sel_write;
      $changed(pump_clock_select_o) |-> !$past(hreadyout_o);
   endproperty
   a_pump_sel_write: assert property (p_pump_sel_write)
      else $error("pump clock select changed outside a write");
   property p_pdown_write;
      $changed(array_power_down_o) |-> !$past(hreadyout_o);
   endproperty
   a_pdown_write: assert property (p_pdown_write)
      else $error("power down changed outside a write");
   // Sync depth of two plus the output flop
   property p_stop_cut;
      stop_mode_i [*4] |-> !hv_request_o;
   endproperty
   a_stop_cut: assert property (p_stop_cut)
      else $error("high voltage on during stop");
   property p_hv_no_stop;
      $rose(hv_request_o) |-> !$past(stop_mode_i, 3);
   endproperty
   a_hv_no_stop: assert property (p_hv_no_stop)
      else $error("high voltage rose while stopped");
endmodule

bind eepc_ctrl eepc_ctrl_chk eepc_ctrl_chk_inst (
   .clock_i(clock_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel_i), .htrans_i(htrans_i),
   .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
   .stop_mode_i(stop_mode_i), .hv_request_o(hv_request_o),
   .pump_clock_select_o(pump_clock_select_o), .array_power_down_o(array_power_down_o)
);

// file: verification/eepc_cpu_model.sv
// Processor model: single-word AHB-Lite master for the register bus.
// Assumes one slave whose hreadyout is fed back as hready_i.
`timescale 1ns/1ps
module eepc_cpu_model (
   input wire logic clock_i,
   input wire logic hready_i,
   input wire logic [31:0] hrdata_i,
   output logic hsel_o,
   output logic [31:0] haddr_o,
   output logic [1:0] htrans_o,
   output logic hwrite_o,
   output logic [2:0] hsize_o,
   output logic [31:0] hwdata_o,
   output logic hang_o
);
   logic rdy_q;
   logic [7:0] rd_q;
   // Idle bus at time zero, word size fixed
   initial begin
      hsel_o = 1'b1;
      haddr_o = 32'h00000000;
      htrans_o = 2'h0;
      hwrite_o = 1'b0;
      hsize_o = 3'h2;
      hwdata_o = 32'h00000000;
      hang_o = 1'b0;
   end
   // Edge samples, so tasks see what the slave showed at the edge
   always @(posedge clock_i) begin
      rdy_q <= hready_i;
      rd_q <= hrdata_i[7:0];
   end
   task automatic await;
      int n;
      n = 0;
      do begin
         @(posedge clock_i);
         #1;
         n++;
      end while (!rdy_q && n < 50);
      if (!rdy_q) hang_o <= 1'b1;
   endtask
   task automatic xfer(input logic wr, input logic [15:0] a, input logic [7:0] d,
         output logic [7:0] q);
      htrans_o <= 2'h2;
      haddr_o <= {16'h0000, a};
      hwrite_o <= wr;
      await();
      htrans_o <= 2'h0;
      hwdata_o <= {24'h000000, d};
      await();
      q = rd_q;
      hwdata_o <= ~{24'h000000, d}; // Released lane must not echo old data
   endtask
endmodule

// file: verification/eepc_ctrl_tb.sv
// Self-checking bench for the program/erase controller.
// Assumes eepc_ctrl holds the array and the processor model drives the bus.
`timescale 1ns/1ps
module eepc_ctrl_tb;
   logic clock_i;
   logic sys_rst_i;
   logic stop_mode_i;
   logic hsel, hwrite, hready, hresp, hang, hv, pclk, pdn;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   int n_fail;
   int num_checks;
   localparam logic [15:0] CTL = 16'hfe1d;
   localparam logic [15:0] NV = 16'hfe1c;
   localparam logic [15:0] SH = 16'hfe1f;
   eepc_ctrl #(.ADDR_W(9)) eepc_ctrl_inst (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
      .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
      .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
      .hresp_o(hresp), .stop_mode_i(stop_mode_i), .hv_request_o(hv),
      .pump_clock_select_o(pclk), .array_power_down_o(pdn));
   eepc_cpu_model eepc_cpu_model_inst (.clock_i(clock_i), .hready_i(hready),
      .hrdata_i(hrdata), .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans),
      .hwrite_o(hwrite), .hsize_o(hsize), .hwdata_o(hwdata), .hang_o(hang));
   // 250 MHz clock
   initial begin
      clock_i = 1'b0;
      forever #2 clock_i = ~clock_i;
   end
   task automatic close_out;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // A stuck bus ends the run as a failure
   always @(posedge hang) begin
      n_fail++;
      close_out();
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tk(input int n);
      repeat (n) begin
         @(posedge clock_i);
         #1;
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      logic [7:0] q;
      eepc_cpu_model_inst.xfer(1'b1, a, d, q);
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] m, input logic [7:0] e);
      logic [7:0] q;
      eepc_cpu_model_inst.xfer(1'b0, a, 8'h00, q);
      chk(q & m, e);
   endtask
   task automatic reset;
      sys_rst_i <= 1'b1;
      tk(16);
      sys_rst_i <= 1'b0;
      tk(3);
   endtask
   // Full latch, enable, release sequence; e says if the pump may start
   task automatic op(input logic [15:0] a, input logic [7:0] d, input logic [1:0] m,
         input logic e);
      wr(CTL, {2'h0, m, 4'h4});
      wr(a, d);
      wr(CTL, {2'h0, m, 4'h5});
      tk(3);
      chk({7'h00, hv}, {7'h00, e});
      wr(CTL, 8'h00);
      rd(CTL, 8'h05, 8'h04);
      wr(CTL, 8'h00);
   endtask
   task automatic t_reset;
      rd(CTL, 8'hff, 8'h00);
      wr(CTL, 8'hc0);
      tk(2);
      chk({6'h00, pclk, pdn}, 8'h03);
      wr(CTL, 8'h00);
      tk(8); // Recovery after power-down
      $display("reset test done");
   endtask
   task automatic t_config;
      op(NV, 8'h00, 2'h1, 1'b1);
      op(NV, 8'h00, 2'h0, 1'b1);
      rd(NV, 8'hff, 8'h00);
      rd(SH, 8'hff, 8'h00);
      wr(SH, 8'hff);
      rd(SH, 8'hff, 8'h00);
      $display("config test done");
   endtask
   task automatic t_array;
      op(16'h0800, 8'h00, 2'h3, 1'b1);
      rd(16'h09ff, 8'hff, 8'hff);
      op(16'h0880, 8'h5a, 2'h0, 1'b1);
      op(16'h0880, 8'h0f, 2'h0, 1'b1);
      rd(16'h0880, 8'hff, 8'h0a);
      op(16'h0800, 8'h5a, 2'h0, 1'b1);
      op(16'h08ff, 8'h00, 2'h2, 1'b1);
      rd(16'h0880, 8'hff, 8'hff);
      rd(16'h0800, 8'hff, 8'h5a);
      op(16'h0800, 8'h00, 2'h1, 1'b1);
      rd(16'h0800, 8'hff, 8'hff);
      wr(CTL, 8'h04);
      wr(16'h0900, 8'h33);
      wr(16'h0901, 8'h44);
      rd(16'h0800, 8'hff, 8'h44);
      wr(CTL, 8'h00);
      rd(16'h0901, 8'hff, 8'hff);
      $display("array test done");
   endtask
   task automatic t_stop;
      wr(CTL, 8'h04);
      wr(16'h0800, 8'h5a);
      wr(CTL, 8'h05);
      tk(3);
      stop_mode_i <= 1'b1; // Deliberate stop under high voltage
      tk(6);
      chk({7'h00, hv}, 8'h00);
      rd(CTL, 8'h01, 8'h01);
      wr(CTL, 8'h35);
      rd(CTL, 8'h31, 8'h01);
      stop_mode_i <= 1'b0;
      tk(6); // Stop recovery
      chk({7'h00, hv}, 8'h01);
      wr(CTL, 8'h04);
      wr(CTL, 8'h00);
      rd(16'h0800, 8'hff, 8'h5a);
      $display("stop test done");
   endtask
   task automatic t_protect;
      op(NV, 8'h00, 2'h1, 1'b1);
      op(NV, 8'h02, 2'h0, 1'b1);
      rd(SH, 8'hff, 8'h00);
      rd(NV, 8'hff, 8'h02);
      rd(SH, 8'hff, 8'h02);
      op(16'h0880, 8'h00, 2'h0, 1'b0);
      rd(16'h0880, 8'hff, 8'hff);
      op(16'h0800, 8'h00, 2'h3, 1'b0);
      $display("protect test done");
   endtask
   task automatic t_redundant;
      op(NV, 8'h00, 2'h1, 1'b1);
      op(NV, 8'h88, 2'h0, 1'b1); // Contents already set
      rd(NV, 8'hff, 8'h88);
      op(16'h0800, 8'h00, 2'h3, 1'b1);
      op(16'h0810, 8'h3c, 2'h0, 1'b1);
      rd(16'h0910, 8'hff, 8'h00);
      // Upper half is not latched here, so the enable bit is refused outright
      wr(CTL, 8'h04);
      wr(16'h0990, 8'h00);
      wr(CTL, 8'h05);
      tk(3);
      chk({7'h00, hv}, 8'h00);
      rd(CTL, 8'h01, 8'h00);
      wr(CTL, 8'h00);
      op(NV, 8'h00, 2'h1, 1'b1);
      op(NV, 8'h00, 2'h0, 1'b1);
      rd(NV, 8'hff, 8'h00);
      rd(16'h0910, 8'hff, 8'h3c);
      reset();
      rd(SH, 8'hff, 8'h00);
      $display("redundant test done");
   endtask
   // Main sequence
   initial begin
      n_fail = 0;
      num_checks = 0;
      sys_rst_i = 1'b1;
      stop_mode_i = 1'b0;
      tk(16);
      sys_rst_i <= 1'b0;
      tk(3);
      t_reset();
      t_config();
      t_array();
      t_stop();
      t_protect();
      t_redundant();
      close_out();
   end
endmodule
